// file: bench/mbac_far_end.sv
// bench: requester model standing in for cpu, copy and coprocessor
`timescale 1ns/1ps
module mbac_far_end
    import mbac_pkg::*;
(
    // clock
    input wire logic i_clk,
    // commands from the bench
    input wire mbac_mreq_s i_mcmd,
    input wire mbac_rreq_s i_rcmd,
    // requests to the checker
    output mbac_mreq_s o_mreq,
    output mbac_rreq_s o_rreq
);
    mbac_mreq_s m_reg;
    mbac_rreq_s r_reg;
    always @(posedge i_clk) begin
        m_reg <= i_mcmd;
        r_reg <= i_rcmd;
    end
    // idle fields flip, so a stale request is never reused by accident
    assign o_mreq = i_mcmd.valid ? i_mcmd : {1'b0, ~m_reg[$bits(m_reg)-2:0]};
    assign o_rreq = i_rcmd.valid ? i_rcmd : {1'b0, ~r_reg[$bits(r_reg)-2:0]};
endmodule

// file: bench/tb.sv
// bench: self-checking testbench for the access checker
`timescale 1ns/1ps
module tb;
    import mbac_pkg::*;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_copy_start = 1'b0;
    logic rd = 1'b0, wr = 1'b0, wt, exc;
    logic [5:0] adr = 6'h00, i_exec_seg = 6'h00;
    logic [31:0] wd = 32'h0, rdat, q_rd, q_ex;
    mbac_mode_e i_mode = MBAC_BOOT;
    mbac_seg_s [MBAC_SEG_N-1:0] i_seg = '0;
    mbac_mreq_s mcmd = '0, mreq;
    mbac_rreq_s rcmd = '0, rreq;
    mbac_resp_s mresp, rresp;
    logic [2:0] mq[$], rq[$];
    int errors = 0, comparisons = 0, seed = 97215, denials = 0;
    // rights per mode: {rd,wr,ex} per region, {rd,wr} per group
    localparam logic [20:0] PM[5] = '{21'h030e05, 21'h1b7f6d, 21'h036e28,
        21'h187140, 21'h000000};
    localparam logic [15:0] PR[5] = '{16'h3cfc, 16'h3ffc, 16'h30e0,
        16'hfc3f, 16'hf000};
    always #2.5 i_clk = ~i_clk;
    mbac_far_end far (.i_clk(i_clk), .i_mcmd(mcmd), .i_rcmd(rcmd),
        .o_mreq(mreq), .o_rreq(rreq));
    mbac_checker dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_mode(i_mode),
        .i_copy_start(i_copy_start), .i_seg(i_seg), .i_exec_seg(i_exec_seg),
        .i_mreq(mreq), .i_rreq(rreq), .o_mresp(mresp), .o_rresp(rresp),
        .o_exception(exc), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wt));
    task chk(input string n, input logic [31:0] got, input logic [31:0] e);
        comparisons++;
        if (got !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, got);
        end
    endtask
    task report_and_stop;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task mem(input mbac_src_e s, input mbac_region_e r, input int op,
            input logic [23:0] a, input logic fe, input logic e);
        mcmd <= '{1'b1, s, op == 0, op == 1, op == 2, r, a, fe, 1'b0};
        rcmd.valid <= 1'b0;
        mq.push_back({2'h0, e});
        @(posedge i_clk);
    endtask
    task rg(input mbac_group_e g, input logic [7:0] sf, input logic w,
            input logic [4:0] h, input logic [2:0] e);
        rcmd <= '{1'b1, !w, w, g, sf, h};
        mcmd.valid <= 1'b0;
        rq.push_back(e);
        if (e[1])
            denials++;
        @(posedge i_clk);
    endtask
    task idle;
        mcmd.valid <= 1'b0;
        rcmd.valid <= 1'b0;
        @(posedge i_clk);
    endtask
    // hold until waitrequest is seen low, release only after that edge
    task av(input logic w, input logic [5:0] a, input logic [31:0] d);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge i_clk);
        end while (wt !== 1'b0);
        q_rd = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge i_clk);
    endtask
    always @(negedge i_clk) begin
        if (mresp.valid === 1'b1) begin
            q_ex = mq.size() ? {29'h0, mq.pop_front()} : 32'hf;
            chk("mem resp", {29'h0, mresp.exc, mresp.mask_read,
                mresp.allow}, q_ex);
        end
        if (rresp.valid === 1'b1) begin
            q_ex = rq.size() ? {29'h0, rq.pop_front()} : 32'hf;
            chk("reg resp", {rresp.allow, exc, rresp.mask_read}, q_ex);
        end
    end
    initial begin
        repeat (5000) @(posedge i_clk);
        errors++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        av(1'b0, MBAC_OFF_STATUS, 32'h0);
        chk("copy mode", {27'h0, q_rd[20:16]}, 32'h1);
        av(1'b1, 6'h3c, 32'hffff_ffff);
        av(1'b0, 6'h3c, 32'h0);
        chk("unmapped", q_rd, 32'h0);
        for (int m = 0; m < 5; m++) begin
            i_mode <= mbac_mode_e'(5'h01 << m);
            for (int r = 0; r < 7; r++)
                for (int op = 0; op < 3; op++)
                    mem(MBAC_SRC_CPU, mbac_region_e'(4'(r)), op,
                        24'($random(seed)), 1'b0, PM[m][3*r+2-op]);
            for (int g = 0; g < 8; g++)
                for (int w = 0; w < 2; w++)
                    rg(mbac_group_e'(4'(g)), 8'h00, w[0], 5'($random(seed)),
                        {PR[m][2*g+1-w], !PR[m][2*g+1-w], 1'b0});
        end
        idle();
        av(1'b1, MBAC_OFF_XBASE_L, 32'hffff_1000);
        av(1'b0, MBAC_OFF_XBASE_L, 32'h0);
        chk("xbase", q_rd, 32'h0000_1000);
        av(1'b1, MBAC_OFF_XSIZE_L, 32'h0000_0100);
        av(1'b1, MBAC_OFF_FWR_L, 32'h0000_0002);
        i_mode <= MBAC_FW;
        mem(MBAC_SRC_CPU, MBAC_R_ARAM, 0, 24'h000fff, 1'b0, 1'b0);
        mem(MBAC_SRC_CPU, MBAC_R_ARAM, 1, 24'h001000, 1'b0, 1'b1);
        mem(MBAC_SRC_CPU, MBAC_R_ARAM, 0, 24'h0010ff, 1'b0, 1'b1);
        mem(MBAC_SRC_CPU, MBAC_R_ARAM, 0, 24'h001100, 1'b0, 1'b0);
        mem(MBAC_SRC_CPU, MBAC_R_SECROW, 0, 24'h0, 1'b0, 1'b1);
        rg(MBAC_G_HW, 8'h00, 1'b0, 5'h01, 3'h4);
        rg(MBAC_G_HW, MBAC_SFR_CLKSEL, 1'b0, 5'h00, 3'h4);
        rg(MBAC_G_HW, MBAC_SFR_CLKSEL, 1'b1, 5'h00, 3'h2);
        rg(MBAC_G_SYSMGT, MBAC_SFR_CPU_CONTROL_STATUS, 1'b0, 5'h00, 3'h4);
        i_seg[0] <= '{1'b1, 1'b0, 1'b0, 24'h100, 24'h1ff, 24'h0, 32'h1};
        i_seg[1] <= '{1'b0, 1'b0, 1'b0, 24'h200, 24'h2ff, 24'h0, '1};
        i_seg[2] <= '{1'b0, 1'b0, 1'b1, 24'h300, 24'h3ff, 24'h0, 32'h4};
        i_mode <= MBAC_USER;
        mem(MBAC_SRC_CPU, MBAC_R_AROM, 0, 24'h000100, 1'b0, 1'b1);
        mem(MBAC_SRC_CPU, MBAC_R_AROM, 0, 24'h0001ff, 1'b0, 1'b1);
        mem(MBAC_SRC_CPU, MBAC_R_AROM, 2, 24'h000180, 1'b0, 1'b0);
        mem(MBAC_SRC_CPU, MBAC_R_AROM, 0, 24'h000200, 1'b0, 1'b0);
        mem(MBAC_SRC_COP, MBAC_R_OPRAM, 1, 24'h0, 1'b0, 1'b1);
        rg(MBAC_G_HW, 8'h00, 1'b1, 5'h00, 3'h4);
        rg(MBAC_G_HW, 8'h00, 1'b0, 5'h01, 3'h2);
        i_exec_seg <= 6'h02;
        rg(MBAC_G_HW, 8'h00, 1'b0, 5'h02, 3'h4);
        rg(MBAC_G_HW, 8'h00, 1'b0, 5'h00, 3'h2);
        rg(MBAC_G_SYSMGT, MBAC_SFR_CPU_CONTROL_STATUS, 1'b0, 5'h00, 3'h4);
        i_mode <= MBAC_SYS;
        rg(MBAC_G_SYSMGT, MBAC_SFR_RPT2, 1'b0, 5'h00, 3'h5);
        rg(MBAC_G_HW, MBAC_SFR_KEY, 1'b0, 5'h00, 3'h5);
        i_copy_start <= 1'b1;
        idle();
        i_copy_start <= 1'b0;
        i_mode <= MBAC_BOOT;
        mem(MBAC_SRC_COPY, MBAC_R_AROM, 0, 24'h0, 1'b0, 1'b1);
        idle();
        av(1'b0, MBAC_OFF_STATUS, 32'h0);
        chk("copy mode", {27'h0, q_rd[20:16]}, 32'h8);
        chk("deny count", {16'h0, q_rd[15:0]}, denials);
        av(1'b1, MBAC_OFF_CFG, 32'h0000_0007);
        i_mode <= MBAC_SYS;
        mem(MBAC_SRC_CPU, MBAC_R_AROM, 0, 24'h0, 1'b1, 1'b0);
        mem(MBAC_SRC_CPU, MBAC_R_AROM, 2, 24'h0, 1'b1, 1'b1);
        mem(MBAC_SRC_COPY, MBAC_R_AROM, 0, 24'h0, 1'b0, 1'b0);
        mem(MBAC_SRC_COPY, MBAC_R_AEE, 0, 24'h0, 1'b0, 1'b0);
        idle();
        repeat (3) @(posedge i_clk);
        if (mq.size() + rq.size() != 0)
            errors++;
        report_and_stop();
    end
endmodule

// file: logic/mbac_checker.sv
// logic: mode based access checker with avalon register slave
`timescale 1ns/1ps
module mbac_checker #(
    parameter int SEG_N = mbac_pkg::MBAC_SEG_N
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // mode and copy control
    input wire mbac_pkg::mbac_mode_e i_mode,
    input wire logic i_copy_start,
    // segment table
    input wire mbac_pkg::mbac_seg_s [SEG_N-1:0] i_seg,
    input wire logic [mbac_pkg::MBAC_SEG_IDX_W-1:0] i_exec_seg,
    // requests
    input wire mbac_pkg::mbac_mreq_s i_mreq,
    input wire mbac_pkg::mbac_rreq_s i_rreq,
    // decisions
    output mbac_pkg::mbac_resp_s o_mresp,
    output mbac_pkg::mbac_resp_s o_rresp,
    output logic o_exception,
    // avalon slave
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest
);
    import mbac_pkg::*;

    typedef struct packed {
        mbac_mode_e copy_mode;
        logic [31:0] cfg;
        logic [31:0] xbase_l;
        logic [31:0] xbase_h;
        logic [31:0] xsize_l;
        logic [31:0] xsize_h;
        logic [31:0] fwr_l;
        logic [31:0] fwr_h;
        logic [15:0] deny_cnt;
        mbac_resp_s mresp;
        mbac_resp_s rresp;
        logic [31:0] rdata;
        logic ack;
    } mbac_state_s;

    mbac_state_s st_reg;
    mbac_state_s st_next;

    ////////////////////////////////////////////////////////////////
    // segment lookup
    logic [SEG_N-1:0] seg_hit;
    logic [SEG_N-1:0] seg_ok;
    logic [31:0] hw_seg_rights;
    logic [MBAC_ADDR_W-1:0] xbase;
    logic [MBAC_ADDR_W-1:0] xsize;
    logic [31:0] fw_rights;

    assign xbase = {st_reg.xbase_h[7:0], st_reg.xbase_l[15:0]};
    assign xsize = {st_reg.xsize_h[7:0], st_reg.xsize_l[15:0]};
    assign fw_rights = {st_reg.fwr_h[MBAC_FWR_HALF_W-1:0],
                        st_reg.fwr_l[MBAC_FWR_HALF_W-1:0]};
    assign hw_seg_rights = i_seg[i_exec_seg].hw;

    genvar g;
    generate
        for (g = 0; g < SEG_N; g++) begin : g_seg
            logic live;
            assign live = i_seg[g].rd | i_seg[g].wr | i_seg[g].ex;
            assign seg_hit[g] = live
                && i_mreq.vaddr >= i_seg[g].first
                && i_mreq.vaddr <= i_seg[g].last;
            assign seg_ok[g] = seg_hit[g]
                && (!i_mreq.rd || i_seg[g].rd)
                && (!i_mreq.wr || i_seg[g].wr)
                && (!i_mreq.ex || i_seg[g].ex);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // memory decision
    mbac_mode_e mmode;
    logic m_allow;
    logic m_deny;
    logic in_xwin;
    logic rx;
    logic rw;
    logic rwx;

    always_comb begin
        // copy machines run in the mode they were started in
        mmode = (i_mreq.src == MBAC_SRC_COPY) ? st_reg.copy_mode
                                               : i_mode;
        rx = !i_mreq.wr;
        rw = !i_mreq.ex;
        rwx = 1'b1;
        in_xwin = i_mreq.vaddr >= xbase
                  && ({1'b0, i_mreq.vaddr}
                      < ({1'b0, xbase} + {1'b0, xsize}));
        m_allow = 1'b0;
        case (mmode)
            MBAC_BOOT: begin
                case (i_mreq.region)
                    MBAC_R_TROM: m_allow = rx;
                    MBAC_R_FEE: m_allow = rwx;
                    MBAC_R_FRAM: m_allow = rw;
                    MBAC_R_SECROW: m_allow = i_mreq.rd && !i_mreq.wr
                                             && !i_mreq.ex;
                    default: m_allow = 1'b0;
                endcase
            end
            MBAC_TEST: begin
                case (i_mreq.region)
                    MBAC_R_TROM, MBAC_R_FROM, MBAC_R_AROM:
                        m_allow = rx;
                    MBAC_R_FEE, MBAC_R_AEE, MBAC_R_SECROW:
                        m_allow = rwx;
                    MBAC_R_FRAM, MBAC_R_ARAM: m_allow = rw;
                    default: m_allow = 1'b0;
                endcase
            end
            MBAC_FW: begin
                case (i_mreq.region)
                    MBAC_R_FROM: m_allow = rx;
                    MBAC_R_FEE: m_allow = rwx;
                    MBAC_R_AEE: m_allow = rw;
                    MBAC_R_SECROW: m_allow = rw;
                    MBAC_R_FRAM: m_allow = rw;
                    MBAC_R_ARAM: m_allow = rw && in_xwin;
                    default: m_allow = 1'b0;
                endcase
            end
            MBAC_SYS: begin
                case (i_mreq.region)
                    MBAC_R_AROM: m_allow = rx;
                    MBAC_R_AEE: m_allow = rwx;
                    MBAC_R_ARAM: m_allow = rw;
                    default: m_allow = 1'b0;
                endcase
            end
            MBAC_USER: begin
                case (i_mreq.region)
                    MBAC_R_AROM: m_allow = rx && |seg_ok;
                    MBAC_R_AEE: m_allow = |seg_ok;
                    MBAC_R_ARAM: m_allow = rw && |seg_ok;
                    default: m_allow = 1'b0;
                endcase
            end
            default: m_allow = 1'b0;
        endcase
        if (i_mreq.src == MBAC_SRC_COP) begin
            m_allow = (i_mreq.region == MBAC_R_OPRAM) && rw;
        end
        // deny terms are evaluated last so they always win
        m_deny = 1'b0;
        if (i_mreq.rd && (i_mreq.region == MBAC_R_TROM
                          || i_mreq.region == MBAC_R_FROM
                          || i_mreq.region == MBAC_R_AROM)) begin
            if (st_reg.cfg[MBAC_CFG_EEROM] && i_mreq.from_ee
                && i_mreq.src == MBAC_SRC_CPU) begin
                m_deny = 1'b1;
            end
            if (st_reg.cfg[MBAC_CFG_CPROM]
                && i_mreq.src == MBAC_SRC_COPY) begin
                m_deny = 1'b1;
            end
        end
        if (i_mreq.rd && st_reg.cfg[MBAC_CFG_CPEE]
            && i_mreq.src == MBAC_SRC_COPY
            && (i_mreq.region == MBAC_R_FEE
                || i_mreq.region == MBAC_R_AEE
                || i_mreq.region == MBAC_R_SECROW)) begin
            m_deny = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // register decision
    logic r_allow;
    logic r_deny;
    logic r_mask;
    logic hw_fw;
    logic hw_usr;

    always_comb begin
        hw_fw = fw_rights[i_rreq.hw_idx];
        hw_usr = hw_seg_rights[i_rreq.hw_idx];
        r_allow = 1'b0;
        case (i_mode)
            MBAC_BOOT: r_allow = i_rreq.group != MBAC_G_TEST;
            MBAC_TEST: r_allow = 1'b1;
            MBAC_FW: begin
                case (i_rreq.group)
                    MBAC_G_FWCFG: r_allow = !i_rreq.wr;
                    MBAC_G_FWOWN: r_allow = 1'b1;
                    MBAC_G_HW: r_allow = hw_fw
                        || (i_rreq.sfr == MBAC_SFR_CLKSEL
                            && !i_rreq.wr);
                    MBAC_G_SYSMGT: r_allow = !i_rreq.wr
                        && i_rreq.sfr == MBAC_SFR_CPU_CONTROL_STATUS;
                    default: r_allow = 1'b0;
                endcase
            end
            MBAC_SYS: begin
                case (i_rreq.group)
                    MBAC_G_SEG, MBAC_G_SYSMGT, MBAC_G_FWCFG, MBAC_G_HW:
                        r_allow = 1'b1;
                    default: r_allow = 1'b0;
                endcase
            end
            MBAC_USER: begin
                case (i_rreq.group)
                    MBAC_G_HW: r_allow = hw_usr;
                    MBAC_G_SYSMGT: r_allow = !i_rreq.wr
                        && i_rreq.sfr == MBAC_SFR_CPU_CONTROL_STATUS;
                    default: r_allow = 1'b0;
                endcase
            end
            default: r_allow = 1'b0;
        endcase
        if (i_rreq.group == MBAC_G_GEN) begin
            r_allow = 1'b1;
        end
        if (i_rreq.group == MBAC_G_BANKED) begin
            r_allow = (i_mode == MBAC_SYS) || (i_mode == MBAC_USER);
        end
        r_deny = (i_rreq.group == MBAC_G_SEG)
                 && (i_mode != MBAC_SYS);
        r_mask = i_rreq.rd
            && ((i_rreq.group == MBAC_G_SYSMGT
                 && i_rreq.sfr == MBAC_SFR_RPT2)
                || (i_rreq.group == MBAC_G_HW
                    && i_rreq.sfr == MBAC_SFR_KEY));
    end

    ////////////////////////////////////////////////////////////////
    // state update and avalon slave
    logic avs_req;
    assign avs_req = (i_avs_read || i_avs_write) && !st_reg.ack;

    always_comb begin
        st_next = st_reg;
        if (i_copy_start) begin
            st_next.copy_mode = i_mode;
        end
        st_next.mresp.valid = i_mreq.valid;
        st_next.mresp.allow = i_mreq.valid && m_allow && !m_deny;
        st_next.mresp.exc = 1'b0;
        st_next.mresp.mask_read = 1'b0;
        st_next.rresp.valid = i_rreq.valid;
        st_next.rresp.allow = i_rreq.valid && r_allow && !r_deny;
        st_next.rresp.exc = i_rreq.valid && !(r_allow && !r_deny);
        st_next.rresp.mask_read = i_rreq.valid && r_mask;
        if (st_next.rresp.exc && st_reg.deny_cnt != 16'hffff) begin
            st_next.deny_cnt = st_reg.deny_cnt + 16'h0001;
        end
        st_next.ack = avs_req;
        if (avs_req && i_avs_write) begin
            case (i_avs_address)
                MBAC_OFF_CFG: st_next.cfg = i_avs_writedata;
                MBAC_OFF_XBASE_L: st_next.xbase_l = i_avs_writedata;
                MBAC_OFF_XBASE_H: st_next.xbase_h = i_avs_writedata;
                MBAC_OFF_XSIZE_L: st_next.xsize_l = i_avs_writedata;
                MBAC_OFF_XSIZE_H: st_next.xsize_h = i_avs_writedata;
                MBAC_OFF_FWR_L: st_next.fwr_l = i_avs_writedata;
                MBAC_OFF_FWR_H: st_next.fwr_h = i_avs_writedata;
                default: st_next.cfg = st_reg.cfg;
            endcase
        end
        if (avs_req && i_avs_read) begin
            case (i_avs_address)
                MBAC_OFF_CFG: st_next.rdata = {29'h0, st_reg.cfg[2:0]};
                MBAC_OFF_XBASE_L: st_next.rdata = {16'h0,
                                                   st_reg.xbase_l[15:0]};
                MBAC_OFF_XBASE_H: st_next.rdata = {24'h0,
                                                   st_reg.xbase_h[7:0]};
                MBAC_OFF_XSIZE_L: st_next.rdata = {16'h0,
                                                   st_reg.xsize_l[15:0]};
                MBAC_OFF_XSIZE_H: st_next.rdata = {24'h0,
                                                   st_reg.xsize_h[7:0]};
                MBAC_OFF_FWR_L: st_next.rdata = {16'h0, st_reg.fwr_l[15:0]};
                MBAC_OFF_FWR_H: st_next.rdata = {16'h0, st_reg.fwr_h[15:0]};
                MBAC_OFF_STATUS: st_next.rdata = {11'h0, st_reg.copy_mode,
                                                  st_reg.deny_cnt};
                default: st_next.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
            st_reg.copy_mode <= MBAC_BOOT;
            st_reg.cfg <= MBAC_CFG_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // low when idle; during a request, low only on the cycle the answer is ready
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !st_reg.ack;
    assign o_avs_readdata = st_reg.rdata;
    assign o_mresp = st_reg.mresp;
    assign o_rresp = st_reg.rresp;
    assign o_exception = st_reg.rresp.exc;

    ////////////////////////////////////////////////////////////////
    // assertions
    a_seg_deny_mode: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_rreq.valid && i_rreq.group == MBAC_G_SEG && i_mode != MBAC_SYS
        |=> !o_rresp.allow && o_exception)
        else $error("segmentation reg allowed outside system mode");
    a_exc_on_deny: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_rresp.valid |-> (o_exception == !o_rresp.allow))
        else $error("exception does not mirror register denial");
    a_rpt2_masked: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_rreq.valid && i_rreq.rd && i_rreq.group == MBAC_G_SYSMGT
        && i_rreq.sfr == MBAC_SFR_RPT2 |=> o_rresp.mask_read)
        else $error("root pointer read not masked");
    a_key_masked: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_rreq.valid && i_rreq.rd && i_rreq.group == MBAC_G_HW
        && i_rreq.sfr == MBAC_SFR_KEY |=> o_rresp.mask_read)
        else $error("key register read not masked");
    a_banked_deny: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_rreq.valid && i_rreq.group == MBAC_G_BANKED
        && (i_mode == MBAC_BOOT || i_mode == MBAC_TEST || i_mode == MBAC_FW)
        |=> !o_rresp.allow)
        else $error("banked cpu reg allowed in privileged mode");
    a_gen_allow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_rreq.valid && i_rreq.group == MBAC_G_GEN |=> o_rresp.allow)
        else $error("general cpu reg denied");
    a_cop_opram: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_mreq.valid && i_mreq.src == MBAC_SRC_COP && !i_mreq.ex
        && i_mreq.region == MBAC_R_OPRAM |=> o_mresp.allow)
        else $error("coprocessor operand ram denied");
    a_copy_rom_blk: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_mreq.valid && i_mreq.src == MBAC_SRC_COPY && i_mreq.rd
        && st_reg.cfg[MBAC_CFG_CPROM] && i_mreq.region == MBAC_R_AROM
        |=> !o_mresp.allow)
        else $error("copy rom read not blocked");
    a_sys_aee: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_mreq.valid && i_mreq.src == MBAC_SRC_CPU && i_mode == MBAC_SYS
        && i_mreq.region == MBAC_R_AEE && !i_mreq.rd
        |=> o_mresp.allow)
        else $error("system mode app eeprom denied");
    a_copy_mode_hold: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        !i_copy_start |=> st_reg.copy_mode == $past(st_reg.copy_mode))
        else $error("copy mode changed without start");
    a_avs_one_wait: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_avs_read && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("avalon answer late");
    c_user_hit: cover property (@(posedge i_clk)
        i_mreq.valid && i_mode == MBAC_USER ##1 o_mresp.allow);
    c_reg_exc: cover property (@(posedge i_clk) o_exception);
    c_fw_xwin: cover property (@(posedge i_clk)
        i_mreq.valid && i_mode == MBAC_FW && i_mreq.region == MBAC_R_ARAM
        ##1 o_mresp.allow);
    c_avs_write: cover property (@(posedge i_clk)
        i_avs_write && !o_avs_waitrequest);
endmodule

// file: shared/mbac_pkg.sv
// package: constants and types for the mode based access checker
package mbac_pkg;
    // cpu modes, one-hot
    typedef enum logic [4:0] {
        MBAC_BOOT = 5'h01,
        MBAC_TEST = 5'h02,
        MBAC_FW   = 5'h04,
        MBAC_SYS  = 5'h08,
        MBAC_USER = 5'h10
    } mbac_mode_e;

    // memory regions as decoded upstream
    typedef enum logic [3:0] {
        MBAC_R_TROM   = 4'h0,
        MBAC_R_FROM   = 4'h1,
        MBAC_R_AROM   = 4'h2,
        MBAC_R_FEE    = 4'h3,
        MBAC_R_AEE    = 4'h4,
        MBAC_R_FRAM   = 4'h5,
        MBAC_R_ARAM   = 4'h6,
        MBAC_R_SECROW = 4'h7,
        MBAC_R_OPRAM  = 4'h8,
        MBAC_R_NONE   = 4'hf
    } mbac_region_e;

    // register groups
    typedef enum logic [3:0] {
        MBAC_G_SEG    = 4'h0,
        MBAC_G_SYSMGT = 4'h1,
        MBAC_G_FWCFG  = 4'h2,
        MBAC_G_FWOWN  = 4'h3,
        MBAC_G_TEST   = 4'h4,
        MBAC_G_HW     = 4'h5,
        MBAC_G_GEN    = 4'h6,
        MBAC_G_BANKED = 4'h7
    } mbac_group_e;

    // requesters
    typedef enum logic [1:0] {
        MBAC_SRC_CPU  = 2'h0,
        MBAC_SRC_COPY = 2'h1,
        MBAC_SRC_COP  = 2'h2
    } mbac_src_e;

    localparam int MBAC_ADDR_W = 24;
    localparam int MBAC_SEG_N = 64;
    localparam int MBAC_SEG_IDX_W = 6;
    localparam int MBAC_HW_RIGHTS_W = 32;
    localparam int MBAC_REG_IDX_W = 5;
    localparam int MBAC_FWR_HALF_W = 16;

    // special register identities within their groups (arbitrary)
    localparam logic [7:0] MBAC_SFR_CPU_CONTROL_STATUS = 8'h01;
    localparam logic [7:0] MBAC_SFR_CLKSEL = 8'h02;
    localparam logic [7:0] MBAC_SFR_RPT2 = 8'h03;
    localparam logic [7:0] MBAC_SFR_KEY = 8'h04;

    // avalon register offsets (byte addresses)
    localparam logic [5:0] MBAC_OFF_CFG = 6'h00;
    localparam logic [5:0] MBAC_OFF_XBASE_L = 6'h04;
    localparam logic [5:0] MBAC_OFF_XBASE_H = 6'h08;
    localparam logic [5:0] MBAC_OFF_XSIZE_L = 6'h0c;
    localparam logic [5:0] MBAC_OFF_XSIZE_H = 6'h10;
    localparam logic [5:0] MBAC_OFF_FWR_L = 6'h14;
    localparam logic [5:0] MBAC_OFF_FWR_H = 6'h18;
    localparam logic [5:0] MBAC_OFF_STATUS = 6'h1c;
    localparam logic [31:0] MBAC_BAD_READ = 32'hdead_beef;
    localparam logic [31:0] MBAC_CFG_RST = 32'h0000_0000;
    localparam int MBAC_CFG_EEROM = 0;
    localparam int MBAC_CFG_CPROM = 1;
    localparam int MBAC_CFG_CPEE = 2;

    // one segment table entry
    typedef struct packed {
        logic rd;
        logic wr;
        logic ex;
        logic [MBAC_ADDR_W-1:0] first;
        logic [MBAC_ADDR_W-1:0] last;
        logic [MBAC_ADDR_W-1:0] reloc;
        logic [MBAC_HW_RIGHTS_W-1:0] hw;
    } mbac_seg_s;

    // memory request
    typedef struct packed {
        logic valid;
        mbac_src_e src;
        logic rd;
        logic wr;
        logic ex;
        mbac_region_e region;
        logic [MBAC_ADDR_W-1:0] vaddr;
        logic from_ee;
        logic fw_from_sys;
    } mbac_mreq_s;

    // register request
    typedef struct packed {
        logic valid;
        logic rd;
        logic wr;
        mbac_group_e group;
        logic [7:0] sfr;
        logic [MBAC_REG_IDX_W-1:0] hw_idx;
    } mbac_rreq_s;

    // decision
    typedef struct packed {
        logic valid;
        logic allow;
        logic exc;
        logic mask_read;
    } mbac_resp_s;
endpackage
